//--- rtl/wdt_wake_pkg.sv
// Package: register map, field positions, timing constants and carriers
package wdt_wake_pkg;
  // Register offsets on the byte bus
  localparam logic [4:0] OFS_WDOG_LOW = 5'h0C;
  localparam logic [4:0] OFS_WDOG_HIGH = 5'h0D;
  localparam logic [4:0] OFS_FLAGS = 5'h0E;
  localparam logic [4:0] OFS_CONTROL_SECOND = 5'h0F;
  // Control register bit positions
  localparam int BIT_TRANSFER_EN = 7;
  localparam int BIT_XTAL_SEL = 6;
  localparam int BIT_BURST_INC_EN = 5;
  localparam int BIT_ALARM_POWER_EN = 4;
  localparam int BIT_ALARM_IRQ_EN = 3;
  localparam int BIT_KICK_IRQ_EN = 2;
  localparam int BIT_WATCHDOG_EN = 1;
  localparam int BIT_WATCHDOG_STEER = 0;
  // Flag register bit positions
  localparam int BIT_POWERFAIL_HOLD_SEL = 5;
  localparam int BIT_POWER_OFF_CTL = 4;
  localparam int BIT_ALARM_FLAG = 3;
  localparam int BIT_KICK_FLAG = 2;
  localparam int BIT_WATCHDOG_FLAG = 1;
  localparam int BIT_IRQ_REQUEST_FLAG = 0;
  // Reset values and BCD digit limits
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [3:0] BCD_NINE = 4'h9;
  localparam logic [3:0] BCD_ZERO = 4'h0;
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_MS = 10;
  localparam int TICK_CYCLES = TICK_MS * 1000000 / CLK_PERIOD_NS;
  localparam int RST_PULSE_MIN_MS = 40;
  localparam int RST_PULSE_MAX_MS = 200;
  localparam int RST_PULSE_MS = 100;
  localparam int RST_PULSE_CYCLES = RST_PULSE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int POWERON_TIMEOUT_MS = 100;
  localparam int POWERON_TIMEOUT_CYCLES =
    POWERON_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int KICK_MIN_PULSE_NS = 100;
  localparam int KICK_MIN_PULSE_CYCLES =
    (KICK_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Byte bus request as seen by the block
  typedef struct packed {
    logic [4:0] addr;
    logic wr;
    logic rd_end;
    logic [7:0] wdata;
  } bus_req_t;

  // Power sequencing phases
  typedef enum logic [1:0] {PS_IDLE, PS_WAIT, PS_ON} pwr_state_t;
endpackage

//--- rtl/bcd_watchdog.sv
// BCD down-counter for the watchdog period
`timescale 1ns/1ps
module bcd_watchdog
  import wdt_wake_pkg::*;
#(
  parameter int TICK_COUNT = TICK_CYCLES
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Control
  input wire logic i_reload,
  input wire logic i_run,
  input wire logic [15:0] i_period,
  // Status
  output logic o_timeout
);
  logic [15:0] count;
  logic [$clog2(TICK_COUNT+1)-1:0] tick_cnt;
  logic tick;
  logic reload_d;
  logic [4:0] d0, d1, d2, d3;

  ////////////////////////////////////////////////////////////////
  // Decrement one BCD digit, returns borrow in bit 4
  function automatic logic [4:0] bcd_dec(input logic [3:0] d);
    if (d == BCD_ZERO) begin
      bcd_dec = {1'b1, BCD_NINE};
    end else begin
      bcd_dec = {1'b0, d - 4'h1};
    end
  endfunction

  // Reload a cycle late: the period registers change on the write edge
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      reload_d <= 1'b0;
    end else begin
      reload_d <= i_reload;
    end
  end

  // Borrow chain across the four digits
  always_comb begin
    d0 = bcd_dec(count[3:0]);
    d1 = d0[4] ? bcd_dec(count[7:4]) : {1'b0, count[7:4]};
    d2 = d1[4] ? bcd_dec(count[11:8]) : {1'b0, count[11:8]};
    d3 = d2[4] ? bcd_dec(count[15:12]) : {1'b0, count[15:12]};
  end

  // 10 ms prescaler, restarted on reload so the period is whole
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || reload_d || !i_run) begin
      tick_cnt <= '0;
    end else if (tick) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
    end
  end
  assign tick = (tick_cnt == ($bits(tick_cnt))'(TICK_COUNT - 1));

  // Four-digit BCD countdown, reloads itself on timeout
  always_ff @(posedge i_ref_clk) begin
    o_timeout <= 1'b0;
    if (i_rst) begin
      count <= '0;
    end else if (reload_d) begin
      count <= i_period;
    end else if (i_run && tick) begin
      if (count == 16'h0001) begin
        count <= i_period;
        o_timeout <= 1'b1;
      end else begin
        count <= {d3[3:0], d2[3:0], d1[3:0], d0[3:0]};
      end
    end
  end
endmodule

//--- rtl/watchdog_wakeup_control.sv
// Watchdog, control register and wakeup/kickstart power sequencing
`timescale 1ns/1ps
// Behaviour
// - Transfer enable gates once-per-second time advance; only software changes it
// - Burst enable steers auto increment of extended RAM address
// - Alarm flag with alarm power enable drives power request active
// - Alarm flag with its interrupt enable sets irq flag; reset clears enable
// - Kick flag with its interrupt enable sets irq flag; reset clears enable
// - Watchdog enable routes timeout to interrupt or reset per steering
// - Steering 0 pulls interrupt low; 1 pulses reset low
// - Period from two BCD registers, 10 ms steps, 0.01 to 99.99 s
// - Counter reloads on timeout and on host write of period
// - Repetitive mode timeout sets watchdog and irq flags, interrupt active
// - Single-shot holds reset 40 to 200 ms then clears watchdog enable
// - Writing zero to both period registers disables the watchdog
// - Disabled watchdog still sets its flag, drives no output
// - On battery with supply low, kick falling edge requests power, sets flag
// - Powered down alarm match with wakeup enabled requests power, sets flag
// - Wakeup only while transfer enable is 1
// - Supply missing at power-on timeout releases power request, irq floats; hold select 1 keeps request driven
// - Successful power-on drives interrupt low, clears power-off bit
// - Setting power-off bit, after flags clear, floats power request
// - With main power, enabled kick or wakeup drives power request
// - Fully powered down: power request held if hold select 1
// - Irq flag is OR of enabled flags; interrupt low when set
// - Reading flags clears them at access end; alarm, watchdog clear on 0
// - Alarm flag with power enable, or kick flag, clears power-off bit
module watchdog_wakeup_control
  import wdt_wake_pkg::*;
#(
  parameter int TICK_COUNT = TICK_CYCLES,
  parameter int RST_PULSE_COUNT = RST_PULSE_CYCLES,
  parameter int POTO_COUNT = POWERON_TIMEOUT_CYCLES
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Byte register port (same clock domain)
  input wire logic [4:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd_end,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  // Calendar side
  input wire logic i_alarm_match,
  input wire logic i_ram_access_end,
  output logic o_transfer_en,
  output logic o_burst_inc,
  // Supply and kick pins (asynchronous)
  input wire logic i_vcc_valid,
  input wire logic i_aux_battery,
  input wire logic i_kick_in_n,
  // Open-drain outputs: output level and enable; reset output is level only
  output logic o_power_request_n,
  output logic o_power_request_oe,
  output logic o_irq_n,
  output logic o_irq_oe,
  output logic o_reset_n
);
  bus_req_t req;
  logic [7:0] control;
  logic [7:0] wdog_low, wdog_high;
  logic alarm_flag, kick_flag, watchdog_flag;
  logic power_off_ctl, powerfail_hold_sel;
  logic irq_request_flag;
  logic timeout, wd_run, wd_reload;
  logic [1:0] vcc_s, aux_s, kick_s;
  logic kick_prev;
  logic [$clog2(KICK_MIN_PULSE_CYCLES+1)-1:0] kick_low_cnt;
  logic kick_event, wake_event;
  logic [$clog2(RST_PULSE_COUNT+1)-1:0] rst_cnt;
  logic rst_active;
  logic [$clog2(POTO_COUNT+1)-1:0] poto_cnt;
  pwr_state_t pstate;
  logic powerup_irq;
  logic vcc, aux;

  assign req = '{addr: i_addr, wr: i_wr, rd_end: i_rd_end, wdata: i_wdata};

  function automatic logic hit(input bus_req_t r, input logic [4:0] a);
    hit = (r.addr == a);
  endfunction

  ////////////////////////////////////////////////////////////////
  // Pin synchronisers
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      vcc_s <= 2'h0;
      aux_s <= 2'h0;
      kick_s <= 2'h3;
    end else begin
      vcc_s <= {vcc_s[0], i_vcc_valid};
      aux_s <= {aux_s[0], i_aux_battery};
      kick_s <= {kick_s[0], i_kick_in_n};
    end
  end
  assign vcc = vcc_s[1];
  assign aux = aux_s[1];

  // Kick low-pulse qualification: event once low lasts the minimum width
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      kick_prev <= 1'b1;
      kick_low_cnt <= '0;
    end else begin
      kick_prev <= kick_s[1];
      if (kick_s[1]) begin
        kick_low_cnt <= '0;
      end else if (kick_low_cnt !=
                   ($bits(kick_low_cnt))'(KICK_MIN_PULSE_CYCLES)) begin
        kick_low_cnt <= kick_low_cnt + 1'b1;
      end
    end
  end
  assign kick_event = aux && !kick_s[1] && !kick_prev &&
    (kick_low_cnt == ($bits(kick_low_cnt))'(KICK_MIN_PULSE_CYCLES - 1));
  // Alarm wakeup needs transfers running
  assign wake_event = i_alarm_match && control[BIT_TRANSFER_EN];

  ////////////////////////////////////////////////////////////////
  // Control register; only watchdog enable is touched by hardware
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      control <= CONTROL_RESET;
    end else begin
      if (req.wr && hit(req, OFS_CONTROL_SECOND)) begin
        control <= req.wdata;
      end
      if (rst_active && rst_cnt == '0) begin
        control[BIT_WATCHDOG_EN] <= 1'b0;
      end
    end
  end
  assign o_transfer_en = control[BIT_TRANSFER_EN];
  assign o_burst_inc = control[BIT_BURST_INC_EN] && i_ram_access_end;

  // Watchdog period registers
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      wdog_low <= BYTE_ZERO;
      wdog_high <= BYTE_ZERO;
    end else if (req.wr) begin
      if (hit(req, OFS_WDOG_LOW)) begin
        wdog_low <= req.wdata;
      end
      if (hit(req, OFS_WDOG_HIGH)) begin
        wdog_high <= req.wdata;
      end
    end
  end
  assign wd_reload = req.wr &&
    (hit(req, OFS_WDOG_LOW) || hit(req, OFS_WDOG_HIGH));
  assign wd_run = (wdog_low != BYTE_ZERO) || (wdog_high != BYTE_ZERO);

  bcd_watchdog #(.TICK_COUNT(TICK_COUNT)) u_wdog (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_reload(wd_reload),
    .i_run(wd_run),
    .i_period({wdog_high, wdog_low}),
    .o_timeout(timeout)
  );

  ////////////////////////////////////////////////////////////////
  // Event flags; a set wins over a read or write clear
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      alarm_flag <= 1'b0;
      kick_flag <= 1'b0;
      watchdog_flag <= 1'b0;
    end else begin
      if (req.rd_end && hit(req, OFS_FLAGS)) begin
        alarm_flag <= 1'b0;
        kick_flag <= 1'b0;
        watchdog_flag <= 1'b0;
      end else if (req.wr && hit(req, OFS_FLAGS)) begin
        alarm_flag <= req.wdata[BIT_ALARM_FLAG];
        kick_flag <= req.wdata[BIT_KICK_FLAG];
        watchdog_flag <= req.wdata[BIT_WATCHDOG_FLAG];
      end
      if (wake_event) begin
        alarm_flag <= 1'b1;
      end
      if (kick_event) begin
        kick_flag <= 1'b1;
      end
      if (timeout) begin
        watchdog_flag <= 1'b1;
      end
    end
  end

  // Power-off and hold-select bits; hardware clear wins over host set
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      power_off_ctl <= 1'b1;
      powerfail_hold_sel <= 1'b0;
    end else begin
      if (req.wr && hit(req, OFS_FLAGS)) begin
        power_off_ctl <= req.wdata[BIT_POWER_OFF_CTL];
        powerfail_hold_sel <= req.wdata[BIT_POWERFAIL_HOLD_SEL];
      end
      if ((alarm_flag && control[BIT_ALARM_POWER_EN]) || kick_flag ||
          pstate == PS_WAIT && vcc) begin
        power_off_ctl <= 1'b0;
      end
    end
  end

  // Enabled flags combine into the request flag
  assign irq_request_flag =
    (alarm_flag && control[BIT_ALARM_IRQ_EN]) ||
    (kick_flag && control[BIT_KICK_IRQ_EN]) ||
    (watchdog_flag && control[BIT_WATCHDOG_EN] &&
     !control[BIT_WATCHDOG_STEER]);

  ////////////////////////////////////////////////////////////////
  // Single-shot reset pulse; fixed mid-range width
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      rst_active <= 1'b0;
      rst_cnt <= '0;
    end else if (rst_active) begin
      if (rst_cnt == '0) begin
        rst_active <= 1'b0;
      end else begin
        rst_cnt <= rst_cnt - 1'b1;
      end
    end else if (timeout && control[BIT_WATCHDOG_EN] &&
                 control[BIT_WATCHDOG_STEER]) begin
      rst_active <= 1'b1;
      rst_cnt <= ($bits(rst_cnt))'(RST_PULSE_COUNT - 1);
    end
  end
  assign o_reset_n = !rst_active;

  ////////////////////////////////////////////////////////////////
  // Power-on sequencing after wakeup or kickstart
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      pstate <= PS_IDLE;
      poto_cnt <= '0;
      powerup_irq <= 1'b0;
    end else begin
      case (pstate)
        PS_IDLE: begin
          if (!vcc && (kick_event ||
              (wake_event && control[BIT_ALARM_POWER_EN]))) begin
            pstate <= PS_WAIT;
            poto_cnt <= ($bits(poto_cnt))'(POTO_COUNT - 1);
          end
        end
        PS_WAIT: begin
          if (vcc) begin
            pstate <= PS_ON;
            powerup_irq <= 1'b1;
          end else if (poto_cnt == '0) begin
            pstate <= PS_IDLE;
          end else begin
            poto_cnt <= poto_cnt - 1'b1;
          end
        end
        PS_ON: begin
          if (!alarm_flag && !kick_flag) begin
            powerup_irq <= 1'b0;
          end
          if (power_off_ctl || !vcc) begin
            pstate <= PS_IDLE;
          end
        end
        default: pstate <= PS_IDLE;
      endcase
    end
  end

  // Power request drive: active low, open drain
  always_comb begin
    o_power_request_n = 1'b0;
    if (pstate == PS_WAIT) begin
      o_power_request_oe = 1'b1;
    end else if (vcc) begin
      o_power_request_oe = !power_off_ctl;
    end else begin
      o_power_request_oe = powerfail_hold_sel && !power_off_ctl;
    end
  end

  // Interrupt drive: only with supply present
  assign o_irq_n = 1'b0;
  assign o_irq_oe = vcc && (irq_request_flag || powerup_irq);

  ////////////////////////////////////////////////////////////////
  // Read data register
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_rdata <= BYTE_ZERO;
    end else begin
      case (req.addr)
        OFS_WDOG_LOW: o_rdata <= wdog_low;
        OFS_WDOG_HIGH: o_rdata <= wdog_high;
        OFS_CONTROL_SECOND: o_rdata <= control;
        OFS_FLAGS: o_rdata <= {2'b00, powerfail_hold_sel, power_off_ctl,
          alarm_flag, kick_flag, watchdog_flag, irq_request_flag};
        default: o_rdata <= BYTE_ZERO;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // Checks
  sequence s_ss_timeout;
    timeout && control[BIT_WATCHDOG_EN] && control[BIT_WATCHDOG_STEER];
  endsequence
  AST_SS_RESET: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    s_ss_timeout and !rst_active |=> !o_reset_n)
    else $error("reset pulse not started");
  AST_REP_IRQ: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    timeout && control[BIT_WATCHDOG_EN] && !control[BIT_WATCHDOG_STEER]
    |=> irq_request_flag)
    else $error("repetitive timeout no irq");
  AST_WD_FLAG: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    timeout |=> watchdog_flag)
    else $error("watchdog flag not set");
  AST_WDE_CLR: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $rose(o_reset_n) |-> !control[BIT_WATCHDOG_EN])
    else $error("enable not cleared after pulse");
  AST_NO_RUN: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !$past(wd_run) |-> !timeout)
    else $error("timeout while disabled");
  AST_IRQ_PIN: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    vcc && irq_request_flag |-> o_irq_oe)
    else $error("irq pin not driven");
  AST_RD_CLR: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    req.rd_end && hit(req, OFS_FLAGS) && !timeout |=> !watchdog_flag)
    else $error("read did not clear flag");
  AST_PAB_CLR: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    kick_flag |=> !power_off_ctl)
    else $error("power off bit not cleared");
  AST_WAKE_TE: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !control[BIT_TRANSFER_EN] && !alarm_flag && !req.wr |=> !alarm_flag)
    else $error("wakeup without transfers");
endmodule

//--- verification/host_bus_model.sv
// Host processor model driving the byte register port
`timescale 1ns/1ps
module host_bus_model
  import wdt_wake_pkg::*;
(
  // Clock
  input wire logic i_ref_clk,
  // Register port toward the device
  output bus_req_t o_req,
  input wire logic [7:0] i_rdata
);
  logic [7:0] ctl_shadow;

  ////////////////////////////////////////////////////////////////////////
  // Idle bus at time zero, no write data qualified yet
  initial begin
    o_req = '{addr: 5'h1F, wr: 1'b0, rd_end: 1'b0, wdata: 8'hA5};
    ctl_shadow = CONTROL_RESET;
  end

  ////////////////////////////////////////////////////////////////////////
  // One write beat; data inverted once released so stale data never helps
  task automatic bus_write(input logic [4:0] a, input logic [7:0] v);
    @(posedge i_ref_clk);
    o_req.addr <= a;
    o_req.wdata <= v;
    o_req.wr <= 1'b1;
    @(posedge i_ref_clk);
    o_req.wr <= 1'b0;
    o_req.wdata <= ~v;
  endtask

  // Register write with the host-side ordering duties
  task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    // Time updates held off while the period changes
    if ((a == OFS_WDOG_LOW || a == OFS_WDOG_HIGH) &&
        ctl_shadow[BIT_TRANSFER_EN]) begin
      ctl_shadow[BIT_TRANSFER_EN] = 1'b0;
      bus_write(OFS_CONTROL_SECOND, ctl_shadow);
    end
    // Power-off only goes out with alarm and kick flags cleared
    if (a == OFS_FLAGS && d[BIT_POWER_OFF_CTL]) begin
      v[BIT_ALARM_FLAG] = 1'b0;
      v[BIT_KICK_FLAG] = 1'b0;
    end
    if (a == OFS_CONTROL_SECOND) begin
      ctl_shadow = d;
    end
    bus_write(a, v);
  endtask

  // Read: data taken two cycles after the address, optional end-of-access pulse
  task automatic rd_reg(input logic [4:0] a, input logic clr,
                        output logic [7:0] d);
    @(posedge i_ref_clk);
    o_req.addr <= a;
    @(posedge i_ref_clk);
    @(posedge i_ref_clk);
    d = i_rdata;
    o_req.rd_end <= clr;
    @(posedge i_ref_clk);
    o_req.rd_end <= 1'b0;
  endtask
endmodule

//--- verification/watchdog_wakeup_control_tb.sv
// Testbench for the watchdog and wakeup control block
`timescale 1ns/1ps
module watchdog_wakeup_control_tb
  import wdt_wake_pkg::*;
();
  localparam int RSTP = 20;
  localparam logic [4:0] CTL = OFS_CONTROL_SECOND;
  localparam logic [4:0] FLG = OFS_FLAGS;
  localparam logic [4:0] LOW = OFS_WDOG_LOW;
  localparam logic [4:0] HIGH = OFS_WDOG_HIGH;
  logic clk, rst, alarm_match, ram_end, vcc, aux, kick_n;
  logic [7:0] rdata;
  logic transfer_en, burst_inc, pr_n, pr_oe, irq_n, irq_oe, reset_n;
  bus_req_t req;
  int fail_count, checks, cycles, n;
  logic [7:0] d, c;

  ////////////////////////////////////////////////////////////////////////
  // Short counts keep the run small
  watchdog_wakeup_control #(.TICK_COUNT(10), .RST_PULSE_COUNT(RSTP),
    .POTO_COUNT(30)) dut_u (
    .i_ref_clk(clk), .i_rst(rst), .i_addr(req.addr), .i_wr(req.wr),
    .i_rd_end(req.rd_end), .i_wdata(req.wdata), .o_rdata(rdata),
    .i_alarm_match(alarm_match), .i_ram_access_end(ram_end),
    .o_transfer_en(transfer_en), .o_burst_inc(burst_inc),
    .i_vcc_valid(vcc), .i_aux_battery(aux), .i_kick_in_n(kick_n),
    .o_power_request_n(pr_n), .o_power_request_oe(pr_oe),
    .o_irq_n(irq_n), .o_irq_oe(irq_oe), .o_reset_n(reset_n));

  host_bus_model host_u (.i_ref_clk(clk), .o_req(req), .i_rdata(rdata));

  // Free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Hang guard, well above the expected run length
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    host_u.wr_reg(a, v);
  endtask

  task automatic rd(input logic [4:0] a, input logic clr);
    host_u.rd_reg(a, clr, d);
  endtask

  function automatic logic pick(input int k);
    case (k)
      0: return pr_oe;
      1: return irq_oe;
      default: return reset_n;
    endcase
  endfunction

  // Bounded wait on an output, then compare it
  task automatic wait_for(input string what, input int k, input logic v,
                          input int lim);
    int i;
    i = 0;
    while (pick(k) !== v && i < lim) begin
      @(posedge clk);
      i++;
    end
    check(what, {7'h00, pick(k)}, {7'h00, v});
  endtask

  task automatic pulse_alarm;
    @(posedge clk);
    alarm_match <= 1'b1;
    @(posedge clk);
    alarm_match <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // Kick pin held low for a number of cycles
  task automatic kick(input int len);
    @(posedge clk);
    kick_n <= 1'b0;
    repeat (len) @(posedge clk);
    kick_n <= 1'b1;
  endtask

  task automatic end_sim;
    if (fail_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst = 1'b1;
    alarm_match = 1'b0;
    ram_end = 1'b0;
    vcc = 1'b1;
    aux = 1'b1;
    kick_n = 1'b1;
    cycles = 0;
    fail_count = 0;
    checks = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    // Reset values and an unmapped place
    rd(CTL, 1'b0);
    check("control_reset", d, CONTROL_RESET);
    rd(FLG, 1'b0);
    check("flags_reset", d, 8'h10);
    wr(5'h1F, 8'hA5);
    rd(5'h1F, 1'b0);
    check("unmapped", d, 8'h00);
    // Control bits reach the calendar side
    for (int j = 0; j < 2; j++) begin
      c = (j == 0) ? 8'hA0 : 8'h00;
      wr(CTL, c);
      rd(CTL, 1'b0);
      check("control_rw", d, c);
      check("transfer_en", {7'h00, transfer_en}, {7'h00, c[7]});
      @(posedge clk);
      ram_end <= 1'b1;
      @(posedge clk);
      check("burst_inc", {7'h00, burst_inc}, {7'h00, c[5]});
      ram_end <= 1'b0;
    end
    // Disabled watchdog, 100 ticks in BCD, restarted by a rewrite
    wr(CTL, 8'h01);
    wr(HIGH, 8'h01);
    wr(LOW, 8'h00);
    repeat (600) @(posedge clk);
    wr(LOW, 8'h00);
    repeat (850) @(posedge clk);
    rd(FLG, 1'b0);
    check("wdog_reload", d & 8'h03, 8'h00);
    repeat (250) @(posedge clk);
    rd(FLG, 1'b0);
    check("wdog_period", d & 8'h03, 8'h02);
    check("wdog_off_irq", {7'h00, irq_oe}, 8'h00);
    check("wdog_off_rst", {7'h00, reset_n}, 8'h01);
    wr(FLG, 8'h10);
    rd(FLG, 1'b0);
    check("flag_write_zero", d & 8'h0F, 8'h00);
    // Repetitive mode with 5 ticks
    wr(CTL, 8'h02);
    wr(HIGH, 8'h00);
    wr(LOW, 8'h05);
    wait_for("irq_repeat", 1, 1'b1, 80);
    rd(FLG, 1'b1);
    check("flags_repeat", d & 8'h03, 8'h03);
    wait_for("irq_read_clear", 1, 1'b0, 3);
    wait_for("irq_again", 1, 1'b1, 60);
    // Zero period stops the watchdog
    wr(LOW, 8'h00);
    wr(FLG, 8'h10);
    repeat (120) @(posedge clk);
    rd(FLG, 1'b0);
    check("wdog_zero", d & 8'h03, 8'h00);
    // Single-shot mode
    wr(CTL, 8'h03);
    wr(LOW, 8'h01);
    wait_for("reset_pulse", 2, 1'b0, 40);
    n = 0;
    while (reset_n === 1'b0 && n < 300) begin
      @(posedge clk);
      n++;
    end
    check("reset_width", {7'h00, (n >= RSTP && n <= RSTP + 3)}, 8'h01);
    rd(CTL, 1'b0);
    check("wde_cleared", d, 8'h01);
    check("single_no_irq", {7'h00, irq_oe}, 8'h00);
    wr(LOW, 8'h00);
    wr(FLG, 8'h10);
    // Kick on battery: short glitch ignored, then power-on timeout
    vcc <= 1'b0;
    kick(3);
    repeat (20) @(posedge clk);
    check("kick_glitch", {7'h00, pr_oe}, 8'h00);
    kick(15);
    wait_for("kick_power", 0, 1'b1, 20);
    wait_for("poweron_timeout", 0, 1'b0, 60);
    check("timeout_irq", {7'h00, irq_oe}, 8'h00);
    rd(FLG, 1'b1);
    check("kick_flag", d & 8'h04, 8'h04);
    // Kick followed by supply coming up
    kick(15);
    vcc <= 1'b1;
    repeat (60) @(posedge clk);
    check("poweron_hold", {7'h00, pr_oe}, 8'h01);
    check("poweron_irq", {7'h00, irq_oe}, 8'h01);
    rd(FLG, 1'b1);
    check("poweron_flags", d & 8'h14, 8'h04);
    // Power-up interrupt drops one cycle after the flags clear
    repeat (2) @(posedge clk);
    check("irq_after_read", {7'h00, irq_oe}, 8'h00);
    check("power_kept", {7'h00, pr_oe}, 8'h01);
    wr(FLG, 8'h10);
    @(posedge clk);
    check("power_off", {7'h00, pr_oe}, 8'h00);
    // Alarm with transfers inhibited, then enabled
    wr(CTL, 8'h10);
    pulse_alarm();
    rd(FLG, 1'b0);
    check("alarm_no_te", d, 8'h10);
    check("alarm_no_te_pwr", {7'h00, pr_oe}, 8'h00);
    wr(CTL, 8'h98);
    pulse_alarm();
    check("alarm_power", {7'h00, pr_oe}, 8'h01);
    check("alarm_irq", {7'h00, irq_oe}, 8'h01);
    rd(FLG, 1'b1);
    check("alarm_flags", d, 8'h09);
    @(posedge clk);
    check("alarm_cleared", {7'h00, irq_oe}, 8'h00);
    // Kick flag set by the host with its interrupt enabled
    wr(CTL, 8'h84);
    wr(FLG, 8'h04);
    @(posedge clk);
    check("kick_irq", {7'h00, irq_oe}, 8'h01);
    rd(FLG, 1'b1);
    check("kick_irq_flags", d & 8'h05, 8'h05);
    // Wakeup disabled with the alarm power enable clear
    wr(CTL, 8'h80);
    wr(FLG, 8'h10);
    pulse_alarm();
    check("wakeup_off", {7'h00, pr_oe}, 8'h00);
    // Power fail with hold select set, then cleared
    wr(FLG, 8'h20);
    vcc <= 1'b0;
    repeat (4) @(posedge clk);
    check("hold_sel_kept", {7'h00, pr_oe}, 8'h01);
    check("pins_low", {6'h00, pr_n, irq_n}, 8'h00);
    wr(FLG, 8'h00);
    @(posedge clk);
    check("hold_sel_off", {7'h00, pr_oe}, 8'h00);
    end_sim();
  end
endmodule
